// *** inc/comparator_control_pkg.sv ***
// Constants, codes and helpers shared by the comparator control block
package comparator_control_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLOCK_PERIOD_NS = 40;       // 25 MHz peripheral clock
    localparam int unsigned COMP_STARTUP_NS = 2500;     // Comparator alone, 2.5 us
    localparam int unsigned REF_STARTUP_NS = 60000;     // With reference, 60 us
    // Least times round up to whole cycles
    localparam int unsigned COMP_STARTUP_CYCLES =
        (COMP_STARTUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned REF_STARTUP_CYCLES =
        (REF_STARTUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned STARTUP_COUNT_WIDTH = 11;   // Holds the longer count

    // ****************************************
    // Register indexes (byte address is four times the index)
    // ****************************************
    localparam logic [2:0] IDX_CONTROL = 3'h0;
    localparam logic [2:0] IDX_INPUT_SELECT = 3'h2;
    localparam logic [2:0] IDX_INT_ENABLE = 3'h6;
    localparam logic [2:0] IDX_STATUS = 3'h7;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned CTL_ENABLE_BIT = 0;
    localparam int unsigned CTL_HYST_LSB = 1;
    localparam int unsigned CTL_LOWPOWER_BIT = 3;
    localparam int unsigned CTL_EDGE_LSB = 4;
    localparam int unsigned CTL_PADOUT_BIT = 6;
    localparam int unsigned CTL_STANDBYRUN_BIT = 7;
    localparam int unsigned SEL_NEG_LSB = 0;
    localparam int unsigned SEL_POS_LSB = 3;
    localparam int unsigned SEL_INVERT_BIT = 7;
    localparam int unsigned INT_ENABLE_BIT = 0;
    localparam int unsigned STAT_FLAG_BIT = 0;
    localparam int unsigned STAT_STATE_BIT = 4;

    // ****************************************
    // Reset values and writable bits
    // ****************************************
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
    localparam logic INT_ENABLE_RESET = 1'h0;
    localparam logic FLAG_RESET = 1'h0;
    localparam logic [7:0] CONTROL_MASK = 8'hff;
    localparam logic [7:0] INPUT_SELECT_MASK = 8'h9b;

    // ****************************************
    // Field codes
    // ****************************************
    localparam logic [1:0] EDGE_ANY_TRANSITION = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_RISING = 2'h3;
    localparam logic [1:0] NEG_PIN_ZERO = 2'h0;
    localparam logic [1:0] NEG_PIN_ONE = 2'h1;
    localparam logic [1:0] NEG_VREF = 2'h2;
    localparam logic [1:0] NEG_CONVERTER = 2'h3;
    localparam logic [1:0] POS_PIN_ZERO = 2'h0;
    localparam logic [1:0] POS_PIN_ONE = 2'h1;
    localparam logic [1:0] SLEEP_ACTIVE = 2'h0;
    localparam logic [1:0] SLEEP_IDLE = 2'h1;
    localparam logic [1:0] SLEEP_STANDBY = 2'h2;
    localparam logic [1:0] SLEEP_POWERDOWN = 2'h3;

    // Start-up sequencer states
    typedef enum logic [1:0] {STARTUP_OFF, STARTUP_WAIT, STARTUP_READY} startup_e;

    // True when a transition prev->cur matches the edge mode
    function automatic logic edgeMatch(input logic [1:0] mode,
                                       input logic prev,
                                       input logic cur);
        logic rise;
        logic fall;
        rise = !prev && cur;
        fall = prev && !cur;
        if (mode == EDGE_ANY_TRANSITION) begin
            edgeMatch = rise || fall;
        end else if (mode == EDGE_FALLING) begin
            edgeMatch = fall;
        end else if (mode == EDGE_RISING) begin
            edgeMatch = rise;
        end else begin
            edgeMatch = 1'b0;  // Reserved code: no edges
        end
    endfunction : edgeMatch

endpackage : comparator_control_pkg

// *** verilog/comparator_control_regs.sv ***
// Register file, synchroniser, start-up timer and edge flag for the analog comparator
//
// Functional notes
// - Enable bit switches comparator on and off
// - Output invalid during start-up, 2.5/60 us
// - Edge field picks both, falling, rising
// - Matching transition sets compare flag
// - Interrupt while flag and enable both set
// - Writing one clears flag, zero ignored
// - Interrupt enable register bit zero
// - State bit follows output three cycles late
// - Invert applies to every output consumer
// - Negative select: pins, reference, converter
// - Positive select zero picks pin zero
// - Pad enable routes output to pin
// - Hysteresis field selects off/10/25/50 mV
// - Low-power bit slows, saves current
// - Output offered as asynchronous event, no inputs
// - Standby halts unless standby run set
// - Idle runs normally, power-down disables
// - Debug halt leaves comparator unchanged
// - Raw output one when positive exceeds negative
`timescale 1ns/1ps
`default_nettype none

module comparator_control_regs
    import comparator_control_pkg::*;
#(
    parameter int unsigned ADDR_WIDTH = 5
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparator core
    input wire logic compRaw,
    output logic compEnable,
    output logic [1:0] hysteresisSelect,
    output logic lowPowerSelect,
    output logic [1:0] positiveInputSelect,
    output logic [1:0] negativeInputSelect,
    output logic outputValid,
    // System side
    input wire logic [1:0] sleepMode,
    output logic eventOut,
    output logic padOut,
    output logic padOutEnable,
    output logic irq
);

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] controlReg;        // Control register
    logic [7:0] selectReg;         // Input select register
    logic intEnable;               // Interrupt enable bit
    logic statusFlag;              // Compare flag, sticky
    logic stateBit;                // Status state bit
    // Next values
    logic [7:0] next_controlReg;
    logic [7:0] next_selectReg;
    logic next_intEnable;
    logic next_statusFlag;
    logic next_irq;

    // Field views
    logic [1:0] edgeSel;
    logic invertSel;
    logic standbyRun;
    assign edgeSel = controlReg[CTL_EDGE_LSB +: 2];
    assign invertSel = selectReg[SEL_INVERT_BIT];
    assign standbyRun = controlReg[CTL_STANDBYRUN_BIT];

    // Analog settings straight from register bits
    // Reserved codes pass as written
    assign hysteresisSelect = controlReg[CTL_HYST_LSB +: 2];
    assign lowPowerSelect = controlReg[CTL_LOWPOWER_BIT];
    assign positiveInputSelect = selectReg[SEL_POS_LSB +: 2];
    assign negativeInputSelect = selectReg[SEL_NEG_LSB +: 2];

    // ****************************************
    // APB access
    // ****************************************
    logic [2:0] regIndex;          // Word index
    logic addrMapped;              // Address hits a register
    logic accessDone;              // Completing access phase
    logic [7:0] readByte;          // Read mux
    // Next answer
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic flagClear;               // Software clear of flag

    assign regIndex = paddr[4:2];
    assign accessDone = psel && penable && pready;

    // Address decode
    // Bad places answer an error
    always_comb begin
        addrMapped = 1'b0;
        readByte = 8'h00;
        if (paddr[1:0] != 2'h0) begin
            addrMapped = 1'b0;
        end else if (regIndex == IDX_CONTROL) begin
            addrMapped = 1'b1;
            readByte = controlReg;
        end else if (regIndex == IDX_INPUT_SELECT) begin
            addrMapped = 1'b1;
            readByte = selectReg;
        end else if (regIndex == IDX_INT_ENABLE) begin
            addrMapped = 1'b1;
            readByte = {7'h00, intEnable};
        end else if (regIndex == IDX_STATUS) begin
            addrMapped = 1'b1;
            readByte = {3'h0, stateBit, 3'h0, statusFlag};
        end
    end

    // One wait state: answer is prepared in the first access cycle
    // Writes land while pready is high
    always_comb begin
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            next_pslverr = !addrMapped;
            next_prdata = (!pwrite && addrMapped) ? {24'h000000, readByte} : 32'h00000000;
        end
    end

    // prdata holds till the next answer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // ****************************************
    // Registers and compare flag
    // ****************************************
    logic writeHit;
    logic edgeHit;                 // Qualified matching transition
    assign writeHit = accessDone && pwrite && addrMapped;
    // Only bit zero acts on status
    assign flagClear = writeHit && regIndex == IDX_STATUS && pwdata[STAT_FLAG_BIT];

    // Next register values; a flag set beats a clear in the same cycle
    // so no edge is lost to a clear
    always_comb begin
        next_controlReg = controlReg;
        next_selectReg = selectReg;
        next_intEnable = intEnable;
        if (writeHit && regIndex == IDX_CONTROL) begin
            next_controlReg = pwdata[7:0] & CONTROL_MASK;
        end
        if (writeHit && regIndex == IDX_INPUT_SELECT) begin
            next_selectReg = pwdata[7:0] & INPUT_SELECT_MASK;
        end
        if (writeHit && regIndex == IDX_INT_ENABLE) begin
            next_intEnable = pwdata[INT_ENABLE_BIT];
        end
        if (edgeHit) begin
            next_statusFlag = 1'b1;
        end else if (flagClear) begin
            next_statusFlag = 1'b0;
        end else begin
            next_statusFlag = statusFlag;
        end
        next_irq = next_statusFlag && next_intEnable;
    end

    // Register fields and flag
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            controlReg <= CONTROL_RESET;
            selectReg <= INPUT_SELECT_RESET;
            intEnable <= INT_ENABLE_RESET;
            statusFlag <= FLAG_RESET;
            irq <= 1'b0;
        end else begin
            controlReg <= next_controlReg;
            selectReg <= next_selectReg;
            intEnable <= next_intEnable;
            statusFlag <= next_statusFlag;
            irq <= next_irq;
        end
    end

    // ****************************************
    // Power state of the comparator
    // ****************************************
    // Next enables
    logic next_compEnable;
    logic next_padOutEnable;
    logic polarOut;                // Output after optional inversion

    // Standby halts unless allowed; power-down always halts; debug has no say
    // Control keeps its value
    always_comb begin
        next_compEnable = controlReg[CTL_ENABLE_BIT];
        if (sleepMode == SLEEP_POWERDOWN) begin
            next_compEnable = 1'b0;
        end else if (sleepMode == SLEEP_STANDBY && !standbyRun) begin
            next_compEnable = 1'b0;
        end
        next_padOutEnable = next_compEnable && controlReg[CTL_PADOUT_BIT];
    end

    // Enables lag sleep by one edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            compEnable <= 1'b0;
            padOutEnable <= 1'b0;
        end else begin
            compEnable <= next_compEnable;
            padOutEnable <= next_padOutEnable;
        end
    end

    // Event and pad paths bypass the clock so they work when it stops
    // No clock needed in standby
    assign polarOut = compRaw ^ invertSel;
    assign eventOut = compEnable && polarOut;
    assign padOut = padOutEnable && polarOut;

    // ****************************************
    // Synchroniser for the state bit
    // ****************************************
    logic syncFirst;               // Metastability catcher
    logic syncSecond;              // Safe copy

    // Three flops: state bit lags the output by three cycles
    // Off core feeds zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            syncFirst <= 1'b0;
            syncSecond <= 1'b0;
            stateBit <= 1'b0;
        end else begin
            syncFirst <= compEnable && polarOut;
            syncSecond <= syncFirst;
            stateBit <= syncSecond;
        end
    end

    // Edge against previous synchronised value, only once output is valid
    // Start-up edges dropped
    assign edgeHit = outputValid && edgeMatch(edgeSel, stateBit, syncSecond);

    // ****************************************
    // Start-up timer
    // ****************************************
    startup_e startupState;
    // Next start-up values
    startup_e next_startupState;
    logic [STARTUP_COUNT_WIDTH-1:0] startupCount;
    logic [STARTUP_COUNT_WIDTH-1:0] next_startupCount;
    logic next_outputValid;
    logic refNeeded;               // Reference must start as well

    // Long start for the reference
    assign refNeeded = negativeInputSelect == NEG_VREF;

    // Wait the longer time when the reference feeds the negative input
    // Counts assume 25 MHz
    always_comb begin
        next_startupState = startupState;
        next_startupCount = startupCount;
        case (startupState)
            STARTUP_OFF: begin
                // Count picked here
                if (next_compEnable) begin
                    next_startupState = STARTUP_WAIT;
                    if (refNeeded) begin
                        next_startupCount =
                            STARTUP_COUNT_WIDTH'(REF_STARTUP_CYCLES - 1);
                    end else begin
                        next_startupCount =
                            STARTUP_COUNT_WIDTH'(COMP_STARTUP_CYCLES - 1);
                    end
                end
            end
            STARTUP_WAIT: begin
                if (startupCount == '0) begin
                    next_startupState = STARTUP_READY;
                end else begin
                    next_startupCount = startupCount - 1'b1;
                end
            end
            default: begin
                next_startupState = STARTUP_READY;
            end
        endcase
        if (!next_compEnable) begin
            next_startupState = STARTUP_OFF;
            next_startupCount = '0;
        end
        next_outputValid = next_startupState == STARTUP_READY;
    end

    // Register start-up state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            startupState <= STARTUP_OFF;
            startupCount <= '0;
            outputValid <= 1'b0;
        end else begin
            startupState <= next_startupState;
            startupCount <= next_startupCount;
            outputValid <= next_outputValid;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Shared clock and reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Flag and request
    a_flag_set: assert property (edgeHit |=> statusFlag)
        else $error("edge did not set flag");
    a_flag_clear: assert property (flagClear && !edgeHit |=> !statusFlag)
        else $error("flag not cleared by one");
    a_flag_hold: assert property (!edgeHit && !flagClear |=> statusFlag == $past(statusFlag))
        else $error("flag changed without cause");
    a_irq_level: assert property (irq == (statusFlag && intEnable))
        else $error("irq does not match flag and enable");

    // Sync and start-up
    a_state_lag: assert property (stateBit == $past(eventOut, 3))
        else $error("state bit not three cycles late");
    a_startup_short: assert property ($rose(outputValid) &&
        !$past(refNeeded, 64) |->
        $past(compEnable, 63) && !$past(compEnable, 64))
        else $error("start-up time wrong");
    a_invalid_blocks: assert property (!outputValid |=> !statusFlag || $past(statusFlag))
        else $error("flag set during start-up");

    // Sleep and events
    a_powerdown_off: assert property (sleepMode == SLEEP_POWERDOWN |=> !compEnable && !padOutEnable)
        else $error("power-down left comparator on");
    a_standby_halt: assert property (sleepMode == SLEEP_STANDBY && !standbyRun |=> !compEnable)
        else $error("standby did not halt");
    a_event_gate: assert property (!compEnable |-> !eventOut)
        else $error("event while disabled");

endmodule : comparator_control_regs

`default_nettype wire

// *** sim/comparator_core_model.sv ***
// Behavioural model of the analog comparator core behind the control block
`timescale 1ns/1ps
`default_nettype none

module comparator_core_model
    import comparator_control_pkg::*;
(
    // Controls from the block
    input wire logic compEnable,
    input wire logic [1:0] hysteresisSelect,
    input wire logic lowPowerSelect,
    input wire logic [1:0] positiveInputSelect,
    input wire logic [1:0] negativeInputSelect,
    // Analog levels in millivolts
    input wire logic [11:0] posPinZero,
    input wire logic [11:0] posPinOne,
    input wire logic [11:0] negPinZero,
    input wire logic [11:0] negPinOne,
    input wire logic [11:0] refLevel,
    input wire logic [11:0] dacLevel,
    // Raw decision towards the block
    output logic compRaw
);
    logic [11:0] posLevel; // Selected positive level
    logic [11:0] negLevel; // Selected negative level
    int diff; // Positive minus negative
    int hyst; // Hysteresis band
    logic decision = 1'b0; // Decision before the reaction delay

    // ****************************************
    // Input selection, hysteresis, decision
    // ****************************************
    always @* begin
        case (hysteresisSelect)
            2'h0: hyst = 0;
            2'h1: hyst = 10;
            2'h2: hyst = 25;
            default: hyst = 50;
        endcase
        case (negativeInputSelect)
            NEG_PIN_ZERO: negLevel = negPinZero;
            NEG_PIN_ONE: negLevel = negPinOne;
            NEG_VREF: negLevel = refLevel;
            default: negLevel = dacLevel;
        endcase
        posLevel = (positiveInputSelect == POS_PIN_ONE) ? posPinOne : posPinZero;
        diff = int'(posLevel) - int'(negLevel);
        if (!compEnable) begin
            decision = 1'b0; // Off core: output low
        end else if (diff > hyst) begin
            decision = 1'b1;
        end else if (diff <= -hyst) begin
            decision = 1'b0;
        end
    end

    // Reduced current answers more slowly
    initial compRaw = 1'b0;
    always @(decision) compRaw <= #(lowPowerSelect ? 200 : 50) decision;
endmodule : comparator_core_model
`default_nettype wire

// *** sim/comparator_control_regs_tb_top.sv ***
// Self-checking testbench of the comparator control registers
`timescale 1ns/1ps
`default_nettype none

module comparator_control_regs_tb_top
    import comparator_control_pkg::*;
;
    logic clock = 1'b0, rst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [4:0] paddr = 5'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, compRaw, compEnable, lowPowerSelect, outputValid;
    logic [1:0] hysteresisSelect, positiveInputSelect, negativeInputSelect;
    logic [1:0] sleepMode = SLEEP_ACTIVE, m;
    logic eventOut, padOut, padOutEnable, irq, err, ie, expFlag;
    logic [11:0] posPinZero = 12'd200, posPinOne = 12'd900, negPinZero = 12'd500;
    logic [11:0] negPinOne = 12'd100, refLevel = 12'd300, dacLevel = 12'd700;
    logic [31:0] seed = 32'h5801; // Random source state
    logic [2:0] idxList [4] = '{IDX_CONTROL, IDX_INPUT_SELECT, IDX_INT_ENABLE, IDX_STATUS};
    logic [1:0] modes [4] = '{EDGE_ANY_TRANSITION, EDGE_FALLING, EDGE_RISING, 2'h1};
    logic [1:0] sleeps [4] = '{SLEEP_IDLE, SLEEP_STANDBY, SLEEP_POWERDOWN, SLEEP_ACTIVE};
    int mismatches = 0, comparisons = 0, n;

    // 25 MHz clock
    always #20 clock = ~clock;

    // Design under test
    comparator_control_regs dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compRaw(compRaw), .compEnable(compEnable),
        .hysteresisSelect(hysteresisSelect), .lowPowerSelect(lowPowerSelect),
        .positiveInputSelect(positiveInputSelect), .negativeInputSelect(negativeInputSelect),
        .outputValid(outputValid), .sleepMode(sleepMode), .eventOut(eventOut),
        .padOut(padOut), .padOutEnable(padOutEnable), .irq(irq));

    // Analog side
    comparator_core_model core_u (.compEnable(compEnable), .hysteresisSelect(hysteresisSelect),
        .lowPowerSelect(lowPowerSelect), .positiveInputSelect(positiveInputSelect),
        .negativeInputSelect(negativeInputSelect), .posPinZero(posPinZero),
        .posPinOne(posPinOne), .negPinZero(negPinZero), .negPinOne(negPinOne),
        .refLevel(refLevel), .dacLevel(dacLevel), .compRaw(compRaw));

    // ****************************************
    // Helpers
    // ****************************************
    // Next random word
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        lfsrNext = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsrNext

    // Whether an edge of the given direction should raise the flag
    function automatic logic edgeExpect(input logic [1:0] mode, input logic rise);
        edgeExpect = (mode == EDGE_ANY_TRANSITION) || (mode == EDGE_RISING && rise) ||
            (mode == EDGE_FALLING && !rise);
    endfunction : edgeExpect

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Wait whole cycles
    task automatic tick(input int cycles);
        repeat (cycles) @(posedge clock);
    endtask : tick

    // One APB transfer, entered just after a rising edge
    task automatic apbXfer(input logic [2:0] idx, input logic wr, input logic [31:0] wd,
                           output logic [31:0] data, output logic slvErr);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        data = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apbXfer

    // Register write
    task automatic regWrite(input logic [2:0] idx, input logic [31:0] wd);
        logic [31:0] unused;
        logic e;
        apbXfer(idx, 1'b1, wd, unused, e);
        check("write error", {31'h0, e}, 32'h0);
    endtask : regWrite

    // Register read
    task automatic regRead(input logic [2:0] idx, output logic [31:0] data);
        logic e;
        apbXfer(idx, 1'b0, 32'h0, data, e);
        check("read error", {31'h0, e}, 32'h0);
    endtask : regRead

    // Verdict and end of run
    task automatic complete_run();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Watchdog against a hang
    initial begin
        tick(20000);
        mismatches++;
        complete_run();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        // Reset values and an unmapped place
        foreach (idxList[i]) begin
            regRead(idxList[i], rd);
            check("reset value", rd, 32'h0);
        end
        check("event idle", {31'h0, eventOut}, 32'h0);
        apbXfer(3'h1, 1'b0, 32'h0, rd, err);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        // Random register contents reach the core controls
        for (int i = 0; i < 4; i++) begin
            seed = lfsrNext(seed);
            regWrite(IDX_CONTROL, {24'h0, seed[7:0]});
            regWrite(IDX_INPUT_SELECT, {24'h0, seed[15:8]});
            regWrite(IDX_INT_ENABLE, {24'h0, seed[23:16]});
            tick(1);
            check("enable out", {31'h0, compEnable}, {31'h0, seed[0]});
            check("hysteresis", {30'h0, hysteresisSelect}, {30'h0, seed[2:1]});
            check("low power", {31'h0, lowPowerSelect}, {31'h0, seed[3]});
            check("pos select", {30'h0, positiveInputSelect}, {30'h0, seed[12:11]});
            check("neg select", {30'h0, negativeInputSelect}, {30'h0, seed[9:8]});
            regRead(IDX_CONTROL, rd);
            check("control", rd, {24'h0, seed[7:0]});
            regRead(IDX_INPUT_SELECT, rd);
            check("input select", rd, {24'h0, seed[15:8] & INPUT_SELECT_MASK});
            regRead(IDX_INT_ENABLE, rd);
            check("int enable", rd, {31'h0, seed[16]});
        end
        // Start-up time with and without the reference
        for (int i = 0; i < 2; i++) begin
            regWrite(IDX_CONTROL, 32'h0);
            regWrite(IDX_INPUT_SELECT, (i == 0) ? {30'h0, NEG_VREF} : 32'h0);
            check("valid off", {31'h0, outputValid}, 32'h0);
            regWrite(IDX_CONTROL, 32'h41);
            n = 0;
            while (outputValid !== 1'b1 && n < 2000) begin
                @(posedge clock);
                n++;
            end
            check("startup", n, (i == 0) ? REF_STARTUP_CYCLES + 1 : COMP_STARTUP_CYCLES + 1);
        end
        // Every edge mode, masked and unmasked interrupt, clearing
        foreach (modes[i]) begin
            m = modes[i];
            seed = lfsrNext(seed);
            ie = seed[0];
            regWrite(IDX_INT_ENABLE, {31'h0, ie});
            regWrite(IDX_CONTROL, {24'h0, 2'b01, m, 4'h1});
            regWrite(IDX_STATUS, 32'h1);
            for (int r = 1; r >= 0; r--) begin
                posPinZero <= (r == 1) ? 12'd800 : 12'd200;
                tick(8);
                expFlag = edgeExpect(m, r[0]);
                check("irq", {31'h0, irq}, {31'h0, expFlag & ie});
                regWrite(IDX_STATUS, 32'h0);
                regRead(IDX_STATUS, rd);
                check("status", rd, {27'h0, r[0], 3'h0, expFlag});
                regWrite(IDX_STATUS, 32'h1);
                regRead(IDX_STATUS, rd);
                check("flag cleared", rd, {27'h0, r[0], 4'h0});
                check("irq cleared", {31'h0, irq}, 32'h0);
            end
        end
        // Inversion reaches event, pad and state; positive pin one
        check("pad enable", {31'h0, padOutEnable}, 32'h1);
        for (int i = 0; i < 2; i++) begin
            regWrite(IDX_INPUT_SELECT, (i == 0) ? 32'h80 : 32'h88);
            tick(8);
            check("event", {31'h0, eventOut}, (i == 0) ? 32'h1 : 32'h0);
            check("pad", {31'h0, padOut}, (i == 0) ? 32'h1 : 32'h0);
            regRead(IDX_STATUS, rd);
            check("state", {27'h0, rd[4:0] & 5'h10}, (i == 0) ? 32'h10 : 32'h0);
        end
        // Standby without run bit halts the core
        sleepMode <= SLEEP_STANDBY;
        tick(2);
        check("standby halt", {30'h0, compEnable, padOutEnable}, 32'h0);
        regWrite(IDX_CONTROL, 32'hc1);
        foreach (sleeps[i]) begin
            sleepMode <= sleeps[i];
            tick(2);
            n = (sleeps[i] == SLEEP_POWERDOWN) ? 0 : 3;
            check("sleep", {30'h0, compEnable, padOutEnable}, 32'(n));
        end
        complete_run();
    end
endmodule : comparator_control_regs_tb_top
`default_nettype wire
